/* File: verilog/spi_crc_pkg.sv */
// shared constants and types for the sensor serial link and its controller
package spi_crc_pkg;
  // frame geometry
  localparam int          FRAME_SHORT = 16;       // command only
  localparam int          FRAME_LONG  = 20;       // command plus checksum
  localparam logic [4:0]  LEN_SHORT   = 5'h10;    // short frame bit count
  localparam logic [4:0]  LEN_LONG    = 5'h14;    // long frame bit count
  localparam logic [4:0]  CNT_SAT     = 5'h1f;    // bit counter saturates here
  // command field positions
  localparam int          SYNC_BIT    = 15;       // must be low
  localparam int          RW_BIT      = 14;       // high for write
  localparam int          ADDR_MSB    = 13;
  localparam int          ADDR_LSB    = 8;
  localparam int          DATA_MSB    = 7;
  // checksum
  localparam logic [3:0]  CRC_INIT    = 4'hf;     // preset value
  localparam logic [3:0]  CRC_POLY    = 4'h3;     // x^4 + x + 1, low terms
  // register addresses the engine itself looks at
  localparam logic [5:0]  ADDR_KEY_HI = 6'h3e;    // access key even byte
  localparam logic [5:0]  ADDR_KEY_LO = 6'h3f;    // access key odd byte
  localparam logic [5:0]  ADDR_ANGLE  = 6'h2a;    // angle output register
  localparam logic [31:0] ACCESS_KEY  = 32'h43555354; // four key bytes, first in msb
  localparam logic [7:0]  SHADOW_OFS  = 8'h20;    // shadow sits above eeprom
  // controller timing
  localparam int          CLK_NS      = 100;      // system clock period
  localparam int          SCLK_HALF_NS = 500;     // half period of the link clock
  localparam int          HALF_CYC    = (SCLK_HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0]  HALF_LAST   = 4'(HALF_CYC - 1);
  localparam logic [3:0]  GAP_LAST    = 4'h7;     // last count of the eight idle cycles between frames
  // controller states
  typedef enum logic [5:0] {
    C_IDLE  = 6'b000001,
    C_LEAD  = 6'b000010,
    C_LOW   = 6'b000100,
    C_HIGH  = 6'b001000,
    C_TRAIL = 6'b010000,
    C_GAP   = 6'b100000
  } ctrl_state_type;
endpackage : spi_crc_pkg

/* File: verilog/spi_link_if.sv */
// four-wire serial link between the controller and the sensor engine
`timescale 1ns/10ps
`default_nettype none
interface spi_link_if;
  logic sclk;   // link clock, idles high
  logic cs_n;   // frame select, active low
  logic mosi;   // controller to sensor
  logic miso;   // sensor to controller
  modport dev  (input sclk, input cs_n, input mosi, output miso);
  modport ctrl (output sclk, output cs_n, output mosi, input miso);
endinterface : spi_link_if
`default_nettype wire

/* File: verilog/crc4_calc.sv */
// combinational 4-bit checksum over a word, msb first, preset to all ones
`timescale 1ns/10ps
`default_nettype none
module crc4_calc
  import spi_crc_pkg::*;
#(
  parameter int WIDTH = 16
) (
  input  wire logic [WIDTH-1:0] data,
  output logic      [3:0]       crc
);
  // bit-serial lfsr unrolled by the loop
  always_comb begin
    logic [3:0] c;
    logic       fb;
    c  = CRC_INIT;
    fb = 1'b0;
    for (int i = WIDTH - 1; i >= 0; i--) begin
      fb = c[3] ^ data[i];
      c  = {c[2:0], 1'b0} ^ (fb ? CRC_POLY : 4'h0);
    end
    crc = c;
  end
endmodule : crc4_calc
`default_nettype wire

/* File: verilog/spi_sensor_dev.sv */
// sensor-side serial command engine: frame decode, checksum, read-back, unlock
// Functional notes
// - checksum register starts at all ones
// - incoming checksum checked only when enabled
// - long frame ignored while checksum disabled
// - bad checksum discards the frame
// - after discard, previous read data returns
// - own checksum driven on bits 17-20
// - clock idles high, mode three
// - write: sync, rw high, address, data
// - one byte per write frame
// - mosi sampled on rising link clock
// - frame acted on at select rising
// - miso carries last read data, else zeros
// - read: sync, rw low, address, dummy
// - after a write, angle register returned
// - next frame returns whole 16-bit register
// - miso changes on falling link clock
// - key is four byte writes in order
// - unlock enables eeprom and shadow writes; here writes go out whatever unlocked says
// - primary registers always reachable
// - shadow sits 0x20 above eeprom; here no eeprom or shadow range is decoded
// - shadow loaded from eeprom at power-up; here nothing is loaded at power-up
`timescale 1ns/10ps
`default_nettype none
module spi_sensor_dev
  import spi_crc_pkg::*;
(
  input  wire logic        clk,        // system clock
  input  wire logic        rst_n,      // async reset, active low
  spi_link_if.dev          lk,         // serial link
  input  wire logic        crc_en,     // nonvolatile checksum enable
  input  wire logic [15:0] rd_data,    // register file contents at rd_addr
  output logic      [5:0]  rd_addr,    // register selected for read-back
  output logic             wr_en,      // one-cycle byte write strobe
  output logic      [5:0]  wr_addr,    // byte address of the write
  output logic      [7:0]  wr_data,    // byte written
  output logic             unlocked,   // customer key accepted
  output logic             crc_err,    // pulse: frame dropped, bad checksum
  output logic             ignored     // pulse: frame dropped, bad length or sync bit high
);

  // link-side state, restarted at the first rising edge of each frame
  typedef struct packed {
    logic [4:0]  cnt;    // rising edges seen in this frame
    logic [19:0] rx_sr;  // received bits, newest in bit 0
  } link_type;

  // system-side state
  typedef struct packed {
    logic        cs_s1;     // select synchroniser
    logic        cs_s2;
    logic        cs_s3;     // edge detect copy
    logic        en_s1;     // enable pin synchroniser
    logic        en_s2;
    logic [15:0] tx_data;   // word sent in the next frame
    logic [3:0]  tx_crc;    // its checksum
    logic [5:0]  rd_addr;
    logic        load_pend; // fetch rd_data next cycle
    logic [1:0]  key_idx;   // key bytes matched so far
    logic        unlocked;
    logic        wr_en;
    logic [5:0]  wr_addr;
    logic [7:0]  wr_data;
    logic        crc_err;
    logic        ignored;
  } sys_type;

  link_type l_ff, nxt_l;
  sys_type  s_ff, nxt_s;
  logic     miso_ff;        // falling-edge output flop
  logic     fresh_ff;       // no bit taken yet in this frame
  logic [4:0] bit_pos;      // bits taken so far in this frame

  logic [15:0] cmd;         // received command word
  logic [3:0]  rx_crc;      // received checksum
  logic [3:0]  calc_rx;     // checksum of received command
  logic [3:0]  calc_tx;     // checksum of outgoing word
  logic [19:0] tx_word;     // data then checksum
  logic [4:0]  tx_idx;      // bit of tx_word for this falling edge
  logic        cs_rise;     // frame just ended
  logic        len_ok;
  logic        crc_ok;
  logic [7:0]  key_byte;    // key byte expected next

  // checksum of the received command
  crc4_calc #(.WIDTH(FRAME_SHORT)) u_crc_rx (
    .data (cmd),
    .crc  (calc_rx)
  );

  // checksum of the word going out
  crc4_calc #(.WIDTH(FRAME_SHORT)) u_crc_tx (
    .data (s_ff.tx_data),
    .crc  (calc_tx)
  );

  // ---------------- link clock domain ----------------

  // shift in and count bits; the first rising edge of a frame restarts both
  always_comb begin
    nxt_l = l_ff;
    if (fresh_ff) begin
      nxt_l.cnt   = 5'h01;
      nxt_l.rx_sr = {19'h00000, lk.mosi};
    end else begin
      if (l_ff.cnt != CNT_SAT) begin
        nxt_l.cnt = l_ff.cnt + 5'h01;
      end
      nxt_l.rx_sr = {l_ff.rx_sr[18:0], lk.mosi};
    end
  end

  // frame-start flag: set while select is high, dropped at the first rising
  // edge; the frame itself is kept so the system side can still decode it
  always_ff @(posedge lk.sclk or posedge lk.cs_n) begin
    if (lk.cs_n) begin
      fresh_ff <= 1'b1;
    end else begin
      fresh_ff <= 1'b0;
    end
  end

  // mosi taken on the rising edge; idle-high clock gives no edge outside
  always_ff @(posedge lk.sclk) begin
    l_ff <= nxt_l;
  end

  // word to send; stable across the frame because the system side
  // only reloads it after select has gone high
  assign tx_word = {s_ff.tx_data, s_ff.tx_crc};
  assign bit_pos = fresh_ff ? 5'h00 : l_ff.cnt;
  assign tx_idx  = 5'(LEN_LONG - 5'h01 - bit_pos);

  // drive miso on falling edges so the controller samples on rising
  always_ff @(negedge lk.sclk or posedge lk.cs_n) begin
    if (lk.cs_n) begin
      miso_ff <= 1'b0;
    end else if (bit_pos < LEN_LONG) begin
      miso_ff <= tx_word[tx_idx];
    end else begin
      miso_ff <= 1'b0;            // past bit 20 nothing is left
    end
  end

  assign lk.miso = miso_ff;

  // ---------------- system clock domain ----------------

  // frame contents are read only after select has settled high,
  // when the link clock is parked and the shift register is quiet
  assign cs_rise  = s_ff.cs_s2 & ~s_ff.cs_s3;
  assign cmd      = s_ff.en_s2 ? l_ff.rx_sr[19:4] : l_ff.rx_sr[15:0];
  assign rx_crc   = l_ff.rx_sr[3:0];
  assign len_ok   = s_ff.en_s2 ? (l_ff.cnt == LEN_LONG)
                               : (l_ff.cnt == LEN_SHORT);
  assign crc_ok   = ~s_ff.en_s2 | (rx_crc == calc_rx);
  assign key_byte = ACCESS_KEY[31 - 8 * s_ff.key_idx -: 8];

  // decode a finished frame and prepare the next answer
  always_comb begin
    nxt_s           = s_ff;
    nxt_s.cs_s1     = lk.cs_n;
    nxt_s.cs_s2     = s_ff.cs_s1;
    nxt_s.cs_s3     = s_ff.cs_s2;
    nxt_s.en_s1     = crc_en;
    nxt_s.en_s2     = s_ff.en_s1;
    nxt_s.wr_en     = 1'b0;
    nxt_s.crc_err   = 1'b0;
    nxt_s.ignored   = 1'b0;
    nxt_s.load_pend = 1'b0;
    nxt_s.tx_crc    = calc_tx;       // follows tx_data by one cycle
    if (s_ff.load_pend) begin
      if (s_ff.wr_en) begin
        nxt_s.load_pend = 1'b1;      // let the register file take the write first
      end else begin
        nxt_s.tx_data = rd_data;     // whole register in one frame
      end
    end
    if (cs_rise) begin
      if (!len_ok || cmd[SYNC_BIT]) begin
        nxt_s.ignored = 1'b1;        // no access, answer unchanged
      end else if (!crc_ok) begin
        nxt_s.crc_err = 1'b1;        // old read data stays queued
      end else if (cmd[RW_BIT]) begin
        // single byte write, any primary address
        nxt_s.wr_en     = 1'b1;
        nxt_s.wr_addr   = cmd[ADDR_MSB:ADDR_LSB];
        nxt_s.wr_data   = cmd[DATA_MSB:0];
        nxt_s.rd_addr   = ADDR_ANGLE;
        nxt_s.load_pend = 1'b1;
        // key bytes must arrive back to back on the key register
        if ((cmd[ADDR_MSB:ADDR_LSB] == ADDR_KEY_HI) ||
            (cmd[ADDR_MSB:ADDR_LSB] == ADDR_KEY_LO)) begin
          if (cmd[DATA_MSB:0] == key_byte) begin
            if (s_ff.key_idx == 2'h3) begin
              nxt_s.unlocked = 1'b1;
              nxt_s.key_idx  = 2'h0;
            end else begin
              nxt_s.key_idx = s_ff.key_idx + 2'h1;
            end
          end else if (cmd[DATA_MSB:0] == ACCESS_KEY[31:24]) begin
            nxt_s.key_idx = 2'h1;    // a fresh first byte restarts
          end else begin
            nxt_s.key_idx = 2'h0;
          end
        end else begin
          nxt_s.key_idx = 2'h0;      // any other write breaks the run
        end
      end else begin
        // read command: select register for the next frame
        nxt_s.rd_addr   = cmd[ADDR_MSB:ADDR_LSB];
        nxt_s.load_pend = 1'b1;
        nxt_s.key_idx   = 2'h0;
      end
    end
  end

  // system registers; answer is all zeros until a command arrives
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_ff       <= '0;
      s_ff.cs_s1 <= 1'b1;
      s_ff.cs_s2 <= 1'b1;
      s_ff.cs_s3 <= 1'b1;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // outputs straight from flops; unlocked gates no write here, and the
  // bench register file applies writes whatever unlocked says, with no
  // eeprom or shadow range and no load at power-up
  assign rd_addr  = s_ff.rd_addr;
  assign wr_en    = s_ff.wr_en;
  assign wr_addr  = s_ff.wr_addr;
  assign wr_data  = s_ff.wr_data;
  assign unlocked = s_ff.unlocked;
  assign crc_err  = s_ff.crc_err;
  assign ignored  = s_ff.ignored;

endmodule : spi_sensor_dev
`default_nettype wire

/* File: verilog/spi_sensor_ctrl.sv */
// controller end: builds frames, makes the link clock, checks answers
`timescale 1ns/10ps
`default_nettype none
module spi_sensor_ctrl
  import spi_crc_pkg::*;
(
  input  wire logic        clk,        // system clock
  input  wire logic        rst_n,      // async reset, active low
  spi_link_if.ctrl         lk,         // serial link
  input  wire logic        start,      // pulse: send cmd
  input  wire logic [15:0] cmd,        // command word
  input  wire logic        long_frame, // append checksum, 20 bits
  output logic             busy,       // frame in progress
  output logic             done,       // pulse: rx_data valid
  output logic      [15:0] rx_data,    // word returned by the sensor
  output logic             rx_crc_ok   // returned checksum matched
);

  typedef struct packed {
    ctrl_state_type state;
    logic [3:0]     div;      // half-period counter
    logic [4:0]     bit_cnt;  // bits completed
    logic [4:0]     nbits;    // frame length
    logic [19:0]    tx_sr;    // outgoing bits, msb first
    logic [19:0]    rx_sr;    // incoming bits
    logic           sclk;
    logic           cs_n;
    logic           mosi;
    logic           m_s1;     // miso synchroniser
    logic           m_s2;
    logic           busy;
    logic           done;
    logic [15:0]    rx_data;
    logic           rx_crc_ok;
  } ctrl_type;

  ctrl_type r_ff, nxt_r;
  logic [3:0] cmd_crc;   // checksum of the command
  logic [3:0] ans_crc;   // checksum of the answer word

  crc4_calc #(.WIDTH(FRAME_SHORT)) u_crc_cmd (
    .data (cmd),
    .crc  (cmd_crc)
  );

  crc4_calc #(.WIDTH(FRAME_SHORT)) u_crc_ans (
    .data (r_ff.rx_sr[19:4]),
    .crc  (ans_crc)
  );

  // frame sequencer; clock idles high, mosi moves on falling edges
  always_comb begin
    nxt_r      = r_ff;
    nxt_r.m_s1 = lk.miso;
    nxt_r.m_s2 = r_ff.m_s1;
    nxt_r.done = 1'b0;
    nxt_r.div  = r_ff.div + 4'h1;
    case (r_ff.state)
      C_IDLE: begin
        nxt_r.div = 4'h0;
        if (start) begin
          nxt_r.tx_sr   = long_frame ? {cmd, cmd_crc} : {cmd, 4'h0};
          nxt_r.nbits   = long_frame ? LEN_LONG : LEN_SHORT;
          nxt_r.bit_cnt = 5'h00;
          nxt_r.cs_n    = 1'b0;
          nxt_r.busy    = 1'b1;
          nxt_r.state   = C_LEAD;
        end
      end
      C_LEAD, C_LOW: begin
        if (r_ff.div == HALF_LAST) begin
          nxt_r.div = 4'h0;
          if (r_ff.state == C_LEAD) begin
            nxt_r.sclk  = 1'b0;           // first falling edge
            nxt_r.mosi  = r_ff.tx_sr[19];
            nxt_r.tx_sr = {r_ff.tx_sr[18:0], 1'b0};
            nxt_r.state = C_LOW;
          end else begin
            nxt_r.sclk  = 1'b1;           // sensor samples here
            nxt_r.state = C_HIGH;
          end
        end
      end
      C_HIGH: begin
        if (r_ff.div == HALF_LAST) begin
          nxt_r.div     = 4'h0;
          nxt_r.rx_sr   = {r_ff.rx_sr[18:0], r_ff.m_s2};
          nxt_r.bit_cnt = r_ff.bit_cnt + 5'h01;
          if (r_ff.bit_cnt == r_ff.nbits - 5'h01) begin
            nxt_r.state = C_TRAIL;
          end else begin
            nxt_r.sclk  = 1'b0;
            nxt_r.mosi  = r_ff.tx_sr[19];
            nxt_r.tx_sr = {r_ff.tx_sr[18:0], 1'b0};
            nxt_r.state = C_LOW;
          end
        end
      end
      C_TRAIL: begin
        if (r_ff.div == HALF_LAST) begin
          nxt_r.div   = 4'h0;
          nxt_r.cs_n  = 1'b1;             // sensor acts on this edge
          nxt_r.mosi  = 1'b0;
          nxt_r.state = C_GAP;
          if (r_ff.nbits == LEN_LONG) begin
            nxt_r.rx_data   = r_ff.rx_sr[19:4];
            nxt_r.rx_crc_ok = (ans_crc == r_ff.rx_sr[3:0]);
          end else begin
            nxt_r.rx_data   = r_ff.rx_sr[15:0];
            nxt_r.rx_crc_ok = 1'b1;
          end
        end
      end
      C_GAP: begin
        // gives the sensor time to reload its answer word
        if (r_ff.div == GAP_LAST) begin
          nxt_r.div   = 4'h0;
          nxt_r.busy  = 1'b0;
          nxt_r.done  = 1'b1;
          nxt_r.state = C_IDLE;
        end
      end
      default: begin
        nxt_r.state = C_IDLE;
      end
    endcase
  end

  // state register; link pins idle with clock and select high
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r_ff       <= '0;
      r_ff.state <= C_IDLE;
      r_ff.sclk  <= 1'b1;
      r_ff.cs_n  <= 1'b1;
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign lk.sclk   = r_ff.sclk;
  assign lk.cs_n   = r_ff.cs_n;
  assign lk.mosi   = r_ff.mosi;
  assign busy      = r_ff.busy;
  assign done      = r_ff.done;
  assign rx_data   = r_ff.rx_data;
  assign rx_crc_ok = r_ff.rx_crc_ok;

endmodule : spi_sensor_ctrl
`default_nettype wire

/* File: tb/spi_link_checker.sv */
// checker for link timing and framing between controller and sensor
`timescale 1ns/10ps
`default_nettype none
module spi_link_checker
  import spi_crc_pkg::*;
(
  input wire logic clk,    // system clock
  input wire logic rst_n,  // async reset, active low
  input wire logic sclk,   // link clock
  input wire logic cs_n,   // frame select
  input wire logic mosi,   // controller data
  input wire logic miso    // sensor data
);
  typedef struct packed {
    logic       sclk;   // link clock one cycle ago
    logic [4:0] rises;  // rising link edges in this frame
  } chk_state_type;
  chk_state_type state_ff;
  chk_state_type nxt_state;
  // count rising link edges while selected
  always_comb begin
    nxt_state      = state_ff;
    nxt_state.sclk = sclk;
    if (cs_n) begin
      nxt_state.rises = 5'h00;
    end else if (sclk && !state_ff.sclk) begin
      nxt_state.rises = state_ff.rises + 5'h01;
    end
  end
  // idle-high reset value so no false edge after reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= '{sclk: 1'b1, rises: 5'h00};
    end else begin
      state_ff <= nxt_state;
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  idle_high_a: assert property (cs_n |-> sclk)
    else $error("link clock low outside a frame");
  lead_high_a: assert property ($fell(cs_n) |-> sclk [*4])
    else $error("link clock not high at frame start");
  low_phase_a: assert property ($fell(sclk) |-> !sclk [*5] ##1 sclk)
    else $error("link clock low phase has wrong length");
  miso_quiet_a: assert property (cs_n |-> !miso)
    else $error("sensor data active while deselected");
  miso_falling_a: assert property ((!cs_n && !$past(cs_n) && !$fell(sclk)) |-> $stable(miso))
    else $error("sensor data moved off a falling link edge");
  mosi_steady_a: assert property (($rose(sclk) && !cs_n) |-> $stable(mosi) [*4])
    else $error("controller data moved around a rising link edge");
  frame_len_a: assert property ($rose(cs_n) |->
    (state_ff.rises == LEN_SHORT || state_ff.rises == LEN_LONG))
    else $error("frame length is neither 16 nor 20 bits");
  gap_a: assert property ($rose(cs_n) |-> cs_n [*8])
    else $error("deselect gap shorter than eight cycles");
endmodule : spi_link_checker
`default_nettype wire

/* File: tb/testbench.sv */
// testbench: controller and sensor face to face, plus a sensor under a rule-breaking driver
`timescale 1ns/10ps
`default_nettype none
module testbench
  import spi_crc_pkg::*;
;
  logic        clk, rst_n, start, long_frame, crc_en, crc_en2;  // driven inputs
  logic [15:0] cmd, rd_data, rd_data2, rx_data, c, cw;          // words
  logic        busy, done, rx_crc_ok, wr_en, unlocked, crc_err;  // design outputs
  logic        ignored, wr_en2, crc_err2, ign2, known, exp_unl;
  logic [5:0]  rd_addr, wr_addr, rd_addr2, wr_addr2, a;
  logic [7:0]  wr_data, wr_data2, mem[64], ref_mem[64];         // reg file and model
  logic [19:0] r;                                               // word seen on miso
  logic [15:0] ans;                                             // expected answer
  int          fails, num_checks, wr_cnt, ign_cnt, wr2_cnt, err_cnt, err2_cnt, ign2_cnt, keyst;
  integer      seed = 12449;
  spi_link_if lk();
  spi_link_if lk2();  // second link, driven by the bench
  spi_sensor_ctrl u_spi_sensor_ctrl (.clk(clk), .rst_n(rst_n), .lk(lk.ctrl), .start(start),
    .cmd(cmd), .long_frame(long_frame), .busy(busy), .done(done), .rx_data(rx_data),
    .rx_crc_ok(rx_crc_ok));
  spi_sensor_dev u_spi_sensor_dev (.clk(clk), .rst_n(rst_n), .lk(lk.dev), .crc_en(crc_en),
    .rd_data(rd_data), .rd_addr(rd_addr), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
    .unlocked(unlocked), .crc_err(crc_err), .ignored(ignored));
  spi_sensor_dev u_spi_sensor_dev2 (.clk(clk), .rst_n(rst_n), .lk(lk2.dev), .crc_en(crc_en2),
    .rd_data(rd_data2), .rd_addr(rd_addr2), .wr_en(wr_en2), .wr_addr(wr_addr2),
    .wr_data(wr_data2), .unlocked(), .crc_err(crc_err2), .ignored(ign2));
  spi_link_checker u_chk (.clk(clk), .rst_n(rst_n), .sclk(lk.sclk), .cs_n(lk.cs_n),
    .mosi(lk.mosi), .miso(lk.miso));
  // register file is combinational so the sensor sees it at once
  assign rd_data  = {mem[{rd_addr[5:1], 1'b0}], mem[{rd_addr[5:1], 1'b1}]};
  assign rd_data2 = {mem[{rd_addr2[5:1], 1'b0}], mem[{rd_addr2[5:1], 1'b1}]};
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // apply writes and count pulses
  always @(posedge clk) begin
    if (wr_en === 1'b1) begin
      mem[wr_addr] <= wr_data;
      wr_cnt++;
    end
    wr2_cnt  += (wr_en2 === 1'b1);
    ign_cnt  += (ignored === 1'b1);
    err_cnt  += (crc_err === 1'b1);
    err2_cnt += (crc_err2 === 1'b1);
    ign2_cnt += (ign2 === 1'b1);
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check
  function automatic logic [3:0] crc4(input logic [15:0] w);
    logic [3:0] q;
    q = 4'hf;
    for (int i = 15; i >= 0; i--) q = {q[2:0], 1'b0} ^ ((q[3] ^ w[i]) ? 4'h3 : 4'h0);
    return q;
  endfunction : crc4
  function automatic logic [15:0] reg16(input logic [5:0] ad);
    return {ref_mem[{ad[5:1], 1'b0}], ref_mem[{ad[5:1], 1'b1}]};
  endfunction : reg16
  // one frame through the controller, then the model steps
  task automatic xfer(input logic [15:0] cm, input logic lf);
    int   n;
    int   wr0;
    int   ig0;
    logic ok;
    n   = 0;
    wr0 = wr_cnt;
    ig0 = ign_cnt;
    ok  = !cm[15] && (lf === crc_en);
    start      <= 1'b1;
    cmd        <= cm;
    long_frame <= lf;
    @(posedge clk);
    start <= 1'b0;
    while (done !== 1'b1 && n < 400) begin
      @(posedge clk);
      n++;
      if (n == 2) check(16'(busy), 16'h1, "busy");
    end
    check(16'(busy), 16'h0, "busy idle");
    fails += (n >= 400);  // a hang counts as a mismatch
    if (known) check(rx_data, ans, "rx_data");
    if (lf) check(16'(rx_crc_ok), 16'h1, "rx_crc_ok");
    if (!ok) begin
      check(16'(ign_cnt - ig0), 16'h1, "ignored");
      known = 1'b0;
    end else if (cm[14]) begin
      check(16'(wr_cnt - wr0), 16'h1, "writes");
      check({wr_addr, wr_data}, cm[13:0], "write");
      ref_mem[cm[13:8]] = cm[7:0];
      if (cm[13:9] == ADDR_KEY_HI[5:1]) begin
        keyst = (cm[7:0] == ACCESS_KEY[31-8*keyst -: 8]) ? keyst + 1 : int'(cm[7:0] == 8'h43);
      end else begin
        keyst = 0;
      end
      if (keyst == 4) begin
        exp_unl = 1'b1;
        keyst   = 0;
      end
      ans   = reg16(ADDR_ANGLE);
      known = 1'b1;
    end else begin
      ans   = reg16(cm[13:8]);
      known = 1'b1;
      keyst = 0;
    end
    check(16'(unlocked), 16'(exp_unl), "unlocked");
    @(posedge clk);
  endtask : xfer
  // bench-made link clock at 12 ns, still outside frames
  task automatic bang(input logic [19:0] w, input int nb);
    r = '0;
    lk2.cs_n = 1'b0;
    #13;
    for (int i = 19; i > 19 - nb; i--) begin
      lk2.sclk = 1'b0;
      lk2.mosi = w[i];
      #6;
      lk2.sclk = 1'b1;
      r = {r[18:0], lk2.miso};
      #6;
    end
    #7;
    lk2.cs_n = 1'b1;
    lk2.mosi = ~lk2.mosi;  // released line shows the inverse
    repeat (12) @(posedge clk);
  endtask : bang
  task automatic give_verdict;
    if (fails == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : give_verdict
  initial begin
    repeat (40000) @(posedge clk);
    fails++;
    give_verdict;
  end
  initial begin
    rst_n = 1'b0;
    start = 1'b0;
    cmd = '0;
    long_frame = 1'b0;
    crc_en = 1'b0;
    crc_en2 = 1'b1;
    lk2.sclk = 1'b1;
    lk2.cs_n = 1'b1;
    lk2.mosi = 1'b0;
    ans = '0;
    known = 1'b1;
    exp_unl = 1'b0;
    for (int i = 0; i < 64; i++) begin
      mem[i] = 8'($random(seed));
      ref_mem[i] = mem[i];
    end
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    // good and faulty frames on the second sensor
    c = {2'b00, 6'h1c, 8'h00};
    cw = {2'b01, 6'h10, 8'ha5};
    bang({c, crc4(c)}, 20);
    check(r[19:4], 16'h0000, "first answer");
    bang({c, ~crc4(c)}, 20);
    check(r[19:4], reg16(6'h1c), "read back");
    check(16'(err2_cnt), 16'h1, "crc errors");
    bang({cw, ~crc4(cw)}, 20);
    check(r[19:4], reg16(6'h1c), "held answer");
    check(16'(r[3:0]), 16'(crc4(r[19:4])), "own checksum");
    check(16'(wr2_cnt), 16'h0, "dropped write");
    @(posedge clk);
    crc_en2 <= 1'b0;
    repeat (4) @(posedge clk);
    bang({cw, crc4(cw)}, 20);
    check(16'(ign2_cnt), 16'h1, "long ignored");
    bang({cw, 4'h0}, 16);
    check(16'(wr2_cnt), 16'h1, "plain write");
    check({wr_addr2, wr_data2}, cw[13:0], "plain write");
    // controller to sensor traffic
    xfer(16'h0000, 1'b0);
    for (int i = 0; i < 6; i++) begin
      a = 6'({$random(seed)} % 60);
      xfer({2'b01, a, 8'($random(seed))}, 1'b0);
      xfer({2'b00, a, 8'($random(seed))}, 1'b0);
      xfer({2'b00, ADDR_ANGLE, 8'h00}, 1'b0);
    end
    // broken key, then the full key
    for (int i = 7; i >= 0; i--) begin
      if (i == 4) xfer(16'h0000, 1'b0);
      else xfer({2'b01, i[0] ? ADDR_KEY_LO : ADDR_KEY_HI, ACCESS_KEY[8*(i%4) +: 8]}, 1'b0);
    end
    for (int i = 3; i >= 0; i--) xfer({2'b01, ADDR_KEY_HI, ACCESS_KEY[8*i +: 8]}, 1'b0);
    crc_en <= 1'b1;
    repeat (4) @(posedge clk);
    xfer({2'b01, 6'h05, 8'h3c}, 1'b1);
    xfer({2'b00, 6'h05, 8'h00}, 1'b1);
    xfer({2'b00, ADDR_ANGLE, 8'h00}, 1'b1);
    xfer({2'b00, 6'h05, 8'h00}, 1'b0);
    xfer({1'b1, 15'($random(seed))}, 1'b1);
    xfer({2'b00, 6'h04, 8'h00}, 1'b1);
    crc_en <= 1'b0;
    repeat (4) @(posedge clk);
    xfer({2'b01, 6'h06, 8'h77}, 1'b1);
    xfer({2'b00, 6'h06, 8'h00}, 1'b0);
    xfer(16'h0000, 1'b0);
    check(16'(err_cnt), 16'h0, "crc errors");
    give_verdict;
  end
endmodule : testbench
`default_nettype wire
